// File: flash_prog_pkg.sv
package flash_prog_pkg;

  localparam logic [7:0] OP_CLEAR_FLAGS    = 8'h50;
  localparam logic [7:0] OP_PROG_SINGLE    = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL      = 8'hA2;
  localparam logic [7:0] OP_PROG_DUAL_EXT  = 8'hD2;
  localparam logic [7:0] OP_PROG_QUAD      = 8'h32;
  localparam logic [7:0] OP_PROG_QUAD_EXT  = 8'h38;
  localparam logic [7:0] OP_PROG_QUAD_4B   = 8'h34;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_ENTER_4B       = 8'hB7;
  localparam logic [7:0] OP_EXIT_4B        = 8'hE9;
  localparam logic [7:0] OP_SUSPEND        = 8'h75;
  localparam logic [7:0] OP_RESUME         = 8'h7A;

  // Flag status bit positions
  localparam int FSR_PROTECT  = 1;
  localparam int FSR_PSUSP    = 2;
  localparam int FSR_PFAIL    = 4;
  localparam int FSR_EFAIL    = 5;
  localparam int FSR_READY    = 7;
  localparam logic [7:0] FSR_RESET = 8'h80;

  // Protocol select codes
  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;

  // Program timing: nominal program time and timeout, in microseconds
  localparam int CLK_MHZ        = 20;
  localparam int PROG_TIME_US   = 120;
  localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_TMO_US    = 1800;
  localparam int PROG_TMO_CYCLES = PROG_TMO_US * CLK_MHZ;

  localparam int PAGE_BYTES = 256;
  localparam int ADDR_BITS  = 32;

endpackage

// File: spi_link_rx.sv
// Link-side deserialiser: runs on the serial clock, hands bytes to clk_i
module spi_link_rx
  import flash_prog_pkg::*;
(
  // Link
  input  wire logic       resetn_i,
  input  wire logic       sclk_i,
  input  wire logic       csn_i,
  input  wire logic [3:0] dq_i,
  input  wire logic [1:0] proto_i,
  input  wire logic [1:0] cmd_width_i,
  input  wire logic [1:0] data_width_i,
  // Byte events
  output logic [7:0]      byte_o,
  output logic            byte_tgl_o,
  output logic            first_o,
  output logic            wide_o,
  output logic            whole_o
);
  logic [7:0] shift_q;
  logic [3:0] bitcnt_q;
  logic [2:0] step_d;
  logic [7:0] next_d;
  logic       in_cmd_q;

  // Opcode width follows the protocol; payload width is chosen by the core
  always_comb begin
    unique case (in_cmd_q ? cmd_width_i : data_width_i)
      2'h1:    step_d = 3'h2;
      2'h2:    step_d = 3'h4;
      default: step_d = 3'h1;
    endcase
    unique case (step_d)
      3'h2:    next_d = {shift_q[5:0], dq_i[1:0]};
      3'h4:    next_d = {shift_q[3:0], dq_i[3:0]};
      default: next_d = {shift_q[6:0], dq_i[0]};
    endcase
  end

  // Data and address bits sampled on the rising serial clock
  always_ff @(posedge sclk_i or posedge csn_i) begin
    if (csn_i) begin
      shift_q  <= 8'h00;
      bitcnt_q <= 4'h0;
      in_cmd_q <= 1'b1;
    end else begin
      shift_q <= next_d;
      if (bitcnt_q + 4'(step_d) >= 4'h8) begin
        bitcnt_q <= 4'h0;
        in_cmd_q <= 1'b0;
      end else begin
        bitcnt_q <= bitcnt_q + 4'(step_d);
      end
    end
  end

  always_ff @(posedge sclk_i or posedge csn_i) begin
    if (csn_i) begin
      first_o <= 1'b1;
    end else if (bitcnt_q + 4'(step_d) >= 4'h8) begin
      first_o <= in_cmd_q;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (!csn_i && bitcnt_q + 4'(step_d) >= 4'h8) begin
      byte_o <= next_d;
      wide_o <= proto_i != PROTO_EXT;
    end
  end

  // Toggle and whole-byte flag survive select rise, so the core sees them
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_tgl_o <= 1'b0;
      whole_o    <= 1'b1;
    end else if (!csn_i) begin
      whole_o <= bitcnt_q + 4'(step_d) >= 4'h8;
      if (bitcnt_q + 4'(step_d) >= 4'h8) byte_tgl_o <= ~byte_tgl_o;
    end
  end
endmodule

// File: flash_prog_core.sv
// Operation
// - opcode 50h clears erase, program and protection error flags
// - command bits on one, two or four lines per protocol
// - no select rise after whole bytes: no program, no flags, latch kept
// - address bits sampled on rising serial clock
// - protected target: skip, keep latch, set flag bits 1 and 4
// - program timeout clears latch and sets program-fail flag
// - 02h single, 32h quad, 38h extended quad program
// - A2h dual, D2h extended dual program
// - programming only turns ones into zeros
// - write-in-progress high while programming, low when done
// - every program end clears the write enable latch
// - status and flag status readable during programming
// - suspend pauses programming once P_WRITE is over (ignored during P_WRITE), resume continues it
// - unaligned data past page end wraps to page start
// - more than a page: only last page-sized bytes programmed
// - fewer than a page: other bytes of page untouched
// - 34h is four-byte quad program with full 32-bit address
// - address width from nonvolatile setting or enter/exit commands
// - four-byte opcodes always 4-byte; others only when mode enabled
// - controller-ready flag low while running, high when done
module flash_prog_core
  import flash_prog_pkg::*;
#(
  parameter int PAGE       = PAGE_BYTES,
  parameter int PROG_CYC   = PROG_CYCLES,
  parameter int TMO_CYC    = PROG_TMO_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Serial link
  input  wire logic        sclk_i,
  input  wire logic        csn_i,
  input  wire logic [3:0]  dq_i,
  // Configuration
  input  wire logic [1:0]  proto_i,
  input  wire logic        nv_addr4_i,
  input  wire logic        wel_set_i,
  input  wire logic        force_fail_i,
  input  wire logic [31:0] protect_lo_i,
  input  wire logic [31:0] protect_hi_i,
  // Status
  output logic             wip_o,
  output logic             wel_o,
  output logic [7:0]       flag_status_o,
  output logic             addr4_o,
  output logic             array_we_o,
  output logic [31:0]      array_addr_o,
  output logic [7:0]       array_mask_o
);
  import flash_prog_pkg::*;

  localparam int PW = $clog2(PAGE);

  typedef enum {S_IDLE, S_OP, S_ADDR, S_DATA, S_DROP} rx_e;
  typedef enum {P_IDLE, P_RUN, P_SUSP, P_WRITE} prog_e;

  rx_e         rx_q;
  prog_e       pg_q;
  logic [7:0]  op_q;
  logic [31:0] addr_q;
  logic [2:0]  abytes_q;
  logic [2:0]  alen_d;
  logic [PW:0] count_q;
  logic [PW-1:0] wptr_q;
  logic [7:0]  page_q [PAGE];
  logic [PAGE-1:0] vld_q;
  logic [PW-1:0] wr_idx_q;
  logic [31:0] timer_q;
  logic [31:0] tmo_q;
  logic [7:0]  fsr_q;
  logic        wel_q;
  logic        addr4_q;
  logic        susp_q;
  logic        is_prog_d;
  logic [1:0]  data_w_d;
  logic [1:0]  cmd_w_d;
  logic        nv_q;
  logic        nv_seen_q;
  logic [3:0]  pin_sync_q;

  // Link crossing: byte toggle and select are two-stage synchronised
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic       rx_first;
  logic       rx_wide;
  logic       rx_whole;
  logic [2:0] tgl_sync_q;
  logic [2:0] cs_sync_q;
  logic       byte_ev;
  logic       cs_rise;

  always_comb begin
    unique case (proto_i)
      PROTO_DUAL: cmd_w_d = 2'h1;
      PROTO_QUAD: cmd_w_d = 2'h2;
      default:    cmd_w_d = 2'h0;
    endcase
  end

  // Payload width follows the opcode
  always_comb begin
    is_prog_d = 1'b1;
    data_w_d  = cmd_w_d;
    unique case (op_q)
      OP_PROG_SINGLE:   data_w_d = cmd_w_d;
      OP_PROG_DUAL:     data_w_d = 2'h1;
      OP_PROG_QUAD:     data_w_d = 2'h2;
      OP_PROG_QUAD_4B:  data_w_d = 2'h2;
      OP_PROG_DUAL_EXT: data_w_d = 2'h1;
      OP_PROG_QUAD_EXT: data_w_d = 2'h2;
      default:          is_prog_d = 1'b0;
    endcase
  end

  spi_link_rx u_rx (
    .resetn_i     (resetn_i),
    .sclk_i       (sclk_i),
    .csn_i        (csn_i),
    .dq_i         (dq_i),
    .proto_i      (proto_i),
    .cmd_width_i  (cmd_w_d),
    .data_width_i (data_w_d),
    .byte_o       (rx_byte),
    .byte_tgl_o   (rx_tgl),
    .first_o      (rx_first),
    .wide_o       (rx_wide),
    .whole_o      (rx_whole)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_sync_q <= 3'h0;
      cs_sync_q  <= 3'h7;
      pin_sync_q <= 4'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], rx_tgl};
      cs_sync_q  <= {cs_sync_q[1:0], csn_i};
      pin_sync_q <= {pin_sync_q[2], force_fail_i, pin_sync_q[0], wel_set_i};
    end
  end

  // Byte data is stable for many link cycles after its toggle
  assign byte_ev = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];

  // Four-byte opcode always uses 32 address bits
  assign alen_d = (op_q == OP_PROG_QUAD_4B || addr4_q || nv_q) ? 3'h4 : 3'h3;

  // Frame decode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_q     <= S_IDLE;
      op_q     <= 8'h00;
      addr_q   <= 32'h0000_0000;
      abytes_q <= 3'h0;
    end else if (cs_rise) begin
      rx_q <= S_IDLE;
    end else if (byte_ev) begin
      unique case (rx_q)
        S_IDLE, S_OP: begin
          op_q     <= rx_byte;
          abytes_q <= 3'h0;
          addr_q   <= 32'h0000_0000;
          rx_q     <= S_OP;
        end
        S_ADDR: begin
          addr_q   <= {addr_q[23:0], rx_byte};
          abytes_q <= abytes_q + 3'h1;
          if (abytes_q + 3'h1 == alen_d) rx_q <= S_DATA;
        end
        default: ;
      endcase
    end else if (rx_q == S_OP) begin
      // Program needs a set latch and an idle engine
      rx_q <= (is_prog_d && wel_q && pg_q == P_IDLE) ? S_ADDR : S_DROP;
    end
  end

  // Page buffer: wrap inside page, last PAGE bytes win
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_q  <= '0;
      count_q <= '0;
      vld_q   <= '0;
    end else if (rx_q == S_ADDR && byte_ev) begin
      wptr_q  <= PW'({addr_q[23:0], rx_byte});
      count_q <= '0;
      vld_q   <= '0;
    end else if (rx_q == S_DATA && byte_ev) begin
      wptr_q       <= wptr_q + 1'b1;
      vld_q[wptr_q] <= 1'b1;
      if (count_q != (PW+1)'(PAGE)) count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_q == S_DATA && byte_ev) page_q[wptr_q] <= rx_byte;
  end

  // Address mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr4_q <= 1'b0;
    end else if (rx_q == S_DROP && cs_rise && op_q == OP_ENTER_4B) begin
      addr4_q <= 1'b1;
    end else if (rx_q == S_DROP && cs_rise && op_q == OP_EXIT_4B) begin
      addr4_q <= 1'b0;
    end
  end

  // Nonvolatile mode pin: two-stage synchroniser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_q      <= 1'b0;
      nv_seen_q <= 1'b0;
    end else begin
      nv_seen_q <= nv_addr4_i;
      nv_q      <= nv_seen_q;
    end
  end

  // Commit only when select rises in data phase with bytes
  logic commit;
  logic prot_hit;
  // Whole-byte flag settles on the last serial edge, long before cs_rise
  assign commit   = cs_rise && rx_q == S_DATA && count_q != '0 && rx_whole;
  assign prot_hit = addr_q >= protect_lo_i && addr_q <= protect_hi_i;

  // Program engine with suspend
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_q     <= P_IDLE;
      timer_q  <= 32'h0000_0000;
      tmo_q    <= 32'h0000_0000;
      wr_idx_q <= '0;
    end else begin
      unique case (pg_q)
        P_IDLE: begin
          if (commit && !prot_hit) begin
            pg_q     <= P_WRITE;
            wr_idx_q <= '0;
            timer_q  <= 32'h0000_0000;
            tmo_q    <= 32'h0000_0000;
          end
        end
        P_WRITE: begin
          wr_idx_q <= wr_idx_q + 1'b1;
          if (wr_idx_q == PW'(PAGE - 1)) pg_q <= P_RUN;
        end
        P_RUN: begin
          timer_q <= timer_q + 32'h1;
          tmo_q   <= tmo_q + 32'h1;
          if (rx_q == S_DROP && cs_rise && op_q == OP_SUSPEND) begin
            pg_q <= P_SUSP;
          end else if (timer_q >= 32'(PROG_CYC) ||
                       tmo_q >= 32'(TMO_CYC) || pin_sync_q[3]) begin
            pg_q <= P_IDLE;
          end
        end
        P_SUSP: begin
          if (rx_q == S_DROP && cs_rise && op_q == OP_RESUME) pg_q <= P_RUN;
        end
        default: pg_q <= P_IDLE;
      endcase
    end
  end

  logic prog_fail;
  assign prog_fail = pg_q == P_RUN && !(rx_q == S_DROP && cs_rise &&
                     op_q == OP_SUSPEND) && timer_q < 32'(PROG_CYC) &&
                     (tmo_q >= 32'(TMO_CYC) || pin_sync_q[3]);

  // Array write port: AND mask only clears bits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      array_we_o   <= 1'b0;
      array_addr_o <= 32'h0000_0000;
      array_mask_o <= 8'hFF;
    end else begin
      array_we_o   <= pg_q == P_WRITE && vld_q[wr_idx_q];
      array_addr_o <= {addr_q[31:PW], wr_idx_q};
      array_mask_o <= vld_q[wr_idx_q] ? page_q[wr_idx_q] : 8'hFF;
    end
  end

  // Write enable latch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wel_q <= 1'b0;
    end else if (pg_q == P_RUN && (timer_q >= 32'(PROG_CYC) || prog_fail)) begin
      wel_q <= 1'b0;
    end else if (pin_sync_q[1] || (rx_q == S_DROP && cs_rise &&
                 op_q == OP_WRITE_ENABLE)) begin
      wel_q <= 1'b1;
    end
  end

  // Flag status: set wins over clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fsr_q <= FSR_RESET;
    end else begin
      if (rx_q == S_OP && op_q == OP_CLEAR_FLAGS) begin
        fsr_q[FSR_PROTECT] <= 1'b0;
        fsr_q[FSR_PFAIL]   <= 1'b0;
        fsr_q[FSR_EFAIL]   <= 1'b0;
      end
      if (commit && prot_hit && pg_q == P_IDLE) begin
        fsr_q[FSR_PROTECT] <= 1'b1;
        fsr_q[FSR_PFAIL]   <= 1'b1;
      end
      if (prog_fail) fsr_q[FSR_PFAIL] <= 1'b1;
      fsr_q[FSR_PSUSP] <= pg_q == P_SUSP;
      fsr_q[FSR_READY] <= pg_q == P_IDLE || pg_q == P_SUSP;
    end
  end

  // Status outputs readable at any time
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wip_o         <= 1'b0;
      wel_o         <= 1'b0;
      flag_status_o <= FSR_RESET;
      addr4_o       <= 1'b0;
    end else begin
      addr4_o       <= addr4_q | nv_q;
      wip_o         <= pg_q != P_IDLE;
      wel_o         <= wel_q;
      flag_status_o <= fsr_q;
    end
  end
endmodule

// File: flash_prog_props.sv
module flash_prog_props
  import flash_prog_pkg::*;
#(
  parameter int PAGE     = PAGE_BYTES,
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int TMO_CYC  = PROG_TMO_CYCLES
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // Controls
  input wire logic        force_fail_i,
  input wire logic        nv_addr4_i,
  input wire logic [31:0] protect_lo_i,
  input wire logic [31:0] protect_hi_i,
  // Status
  input wire logic        wip_o,
  input wire logic        wel_o,
  input wire logic [7:0]  flag_status_o,
  input wire logic        addr4_o,
  input wire logic        array_we_o,
  input wire logic [31:0] array_addr_o
);
  wire logic rdy = flag_status_o[FSR_READY];
  wire logic prt = flag_status_o[FSR_PROTECT];
  wire logic pfl = flag_status_o[FSR_PFAIL];
  wire logic sus = flag_status_o[FSR_PSUSP];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  we_in_op_a: assert property (array_we_o |-> wip_o)
    else $error("write pulse while idle");
  start_we_a: assert property ($rose(wip_o) |-> ##[0:20] array_we_o)
    else $error("program started without writes");
  busy_rdy_a: assert property (wip_o && $past(wip_o) && !sus &&
    !$past(sus) |-> !rdy) else $error("ready shown while busy");
  end_rdy_a: assert property ($fell(wip_o) |-> ##[0:2] rdy)
    else $error("ready missing at end");
  end_wel_a: assert property ($fell(wip_o) |-> ##[0:2] !wel_o)
    else $error("latch kept after program");
  tmo_fail_a: assert property (wip_o && force_fail_i |-> ##[0:300] pfl)
    else $error("timeout without fail flag");
  prot_wel_a: assert property ($rose(prt) |-> wel_o && !wip_o && pfl)
    else $error("protected program mishandled");
  we_range_a: assert property (array_we_o |->
    array_addr_o < protect_lo_i || array_addr_o > protect_hi_i)
    else $error("write inside protected range");
  nv_mode_a: assert property (nv_addr4_i [*4] |-> addr4_o)
    else $error("nonvolatile address mode ignored");
  cover property ($fell(wip_o));
  cover property ($rose(prt));
  cover property ($rose(sus));
endmodule

bind flash_prog_core flash_prog_props #(
  .PAGE(PAGE), .PROG_CYC(PROG_CYC), .TMO_CYC(TMO_CYC)
) props (.clk_i, .resetn_i, .force_fail_i, .nv_addr4_i, .protect_lo_i,
  .protect_hi_i, .wip_o, .wel_o, .flag_status_o, .addr4_o, .array_we_o,
  .array_addr_o);

// File: spi_host_model.sv
module spi_host_model (
  // Link
  output logic       sclk_o,
  output logic       csn_o,
  output logic [3:0] dq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    dq_o = 4'hA;
  end
  // Bytes go MSB first; sclk parks low between bytes to pace the core
  task automatic send(input logic [7:0] q[$], input int ln, input int ex);
    logic [7:0] b;
    csn_o = 1'b0;
    #20;
    foreach (q[i]) begin
      b = q[i];
      for (int k = 0; k < 8; k += ln) begin
        dq_o = (ln == 4) ? b[7:4] : (ln == 2) ? {~dq_o[3:2], b[7:6]}
             : {~dq_o[3:1], b[7]};
        #6 sclk_o = 1'b1;
        #6 sclk_o = 1'b0;
        b = b << ln;
      end
      #400;
    end
    // Stray clocks leave a broken last byte
    repeat (ex) begin
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #20 csn_o = 1'b1;
    dq_o = ~dq_o;
    #250;
  endtask
endmodule

// File: serial_flash_program_path_bench.sv
module serial_flash_program_path_bench;
  import flash_prog_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PG = 16;
  localparam int PC = 100;
  localparam int TC = 200;
  typedef struct { logic [31:0] base; logic [7:0] img [PG]; int run; } note_s;
  logic        clk_i = 1'b0;
  logic        resetn_i, sclk_i, csn_i, nv_addr4_i, wel_set_i, force_fail_i;
  logic [3:0]  dq_i;
  logic [1:0]  proto_i;
  logic [31:0] protect_lo_i, protect_hi_i, array_addr_o;
  logic        wip_o, wel_o, addr4_o, array_we_o;
  logic [7:0]  flag_status_o, array_mask_o;
  logic [7:0]  got [PG];
  logic [31:0] gbase;
  note_s       notes [$];
  int          failures, cmp_count, pulses, p0;
  always #25 clk_i = ~clk_i;
  flash_prog_core #(.PAGE(PG), .PROG_CYC(PC), .TMO_CYC(TC)) uut (
    .clk_i, .resetn_i, .sclk_i, .csn_i, .dq_i, .proto_i, .nv_addr4_i,
    .wel_set_i, .force_fail_i, .protect_lo_i, .protect_hi_i, .wip_o,
    .wel_o, .flag_status_o, .addr4_o, .array_we_o, .array_addr_o,
    .array_mask_o);
  spi_host_model host (.sclk_o(sclk_i), .csn_o(csn_i), .dq_o(dq_i));
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_wip(input logic v);
    int k;
    for (k = 0; k < 400 && wip_o !== v; k++) @(negedge clk_i);
    if (k == 400) begin
      chk("wip_o", v, ~v);
      wrap_up();
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int ln);
    logic [7:0] q[$];
    q = {op};
    host.send(q, ln, 0);
    idle(4);
  endtask
  // Expected page image: later bytes overwrite earlier ones in the page
  task automatic prog(input logic [7:0] op, input int ln, input logic [31:0] a,
                      input int na, n, ex, run);
    logic [7:0] q[$];
    note_s      nt;
    logic [7:0] d;
    nt.base = a & ~32'(PG - 1);
    nt.run = run;
    foreach (nt.img[i]) nt.img[i] = 8'hFF;
    q.push_back(op);
    for (int i = na - 1; i >= 0; i--) q.push_back(a[8*i +: 8]);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      nt.img[(a + 32'(i)) % PG] = d;
    end
    if (run != 0) notes.push_back(nt);
    host.send(q, ln, ex);
  endtask
  always @(negedge clk_i) begin
    if (array_we_o === 1'b1) begin
      got[array_addr_o % PG] &= array_mask_o;
      gbase = array_addr_o & ~32'(PG - 1);
      pulses++;
    end
  end
  always @(negedge wip_o) begin
    if (notes.size() > 0) begin
      if (notes[0].run == 1) begin
        chk("page base", notes[0].base, gbase);
        foreach (got[i]) chk("page byte", notes[0].img[i], got[i]);
      end
      void'(notes.pop_front());
      foreach (got[i]) got[i] = 8'hFF;
    end
  end
  initial begin
    foreach (got[i]) got[i] = 8'hFF;
    {resetn_i, nv_addr4_i, wel_set_i, force_fail_i} = 4'h0;
    proto_i = PROTO_EXT;
    protect_lo_i = 32'h0000_1000;
    protect_hi_i = 32'h0000_1FFF;
    void'($urandom(22));
    idle(5);
    resetn_i = 1'b1;
    idle(4);
    chk("flag_status_o", FSR_RESET, flag_status_o);
    chk("array_mask_o", 8'hFF, array_mask_o);
    for (int i = 0; i < 6; i++) begin
      proto_i = (i == 0) ? PROTO_EXT : (i < 3) ? PROTO_DUAL : PROTO_QUAD;
      cmd(OP_WRITE_ENABLE, 1 << proto_i);
      chk("wel_o", 1, wel_o);
      case (i)
        0: prog(OP_PROG_SINGLE, 1, 32'h209, 3, PG + 5, 0, 1);
        1: prog(OP_PROG_DUAL, 2, 32'h309, 3, 5, 0, 1);
        2: prog(OP_PROG_DUAL_EXT, 2, 32'h409, 3, 5, 0, 1);
        3: prog(OP_PROG_QUAD, 4, 32'h509, 3, 5, 0, 1);
        4: prog(OP_PROG_QUAD_EXT, 4, 32'h609, 3, 5, 0, 1);
        default: prog(OP_PROG_QUAD_4B, 4, 32'h0200_0043, 4, 5, 0, 1);
      endcase
      wait_wip(1);
      idle(2);
      chk("flag_status_o", 8'h00, flag_status_o);
      wait_wip(0);
      idle(3);
      chk("wel_o", 0, wel_o);
      chk("flag_status_o", FSR_RESET, flag_status_o);
    end
    $display("program opcodes test done");
    proto_i = PROTO_EXT;
    p0 = pulses;
    prog(OP_PROG_SINGLE, 1, 32'h40, 3, 4, 0, 0);
    idle(20);
    chk("pulses", p0, pulses);
    chk("flag_status_o", FSR_RESET, flag_status_o);
    wel_set_i = 1'b1;
    idle(1);
    wel_set_i = 1'b0;
    idle(3);
    prog(OP_PROG_SINGLE, 1, 32'h1010, 3, 4, 0, 0);
    idle(20);
    chk("flag_status_o", 8'h92, flag_status_o);
    chk("wel_o", 1, wel_o);
    cmd(OP_CLEAR_FLAGS, 1);
    chk("flag_status_o", FSR_RESET, flag_status_o);
    prog(OP_PROG_SINGLE, 1, 32'h40, 3, 4, 3, 0);
    idle(20);
    chk("pulses", p0, pulses);
    chk("wel_o", 1, wel_o);
    chk("flag_status_o", FSR_RESET, flag_status_o);
    $display("refusal test done");
    prog(OP_PROG_SINGLE, 1, 32'h700, 3, 2, 0, 1);
    wait_wip(1);
    idle(PG + 4);
    cmd(OP_SUSPEND, 1);
    chk("suspend flag", 1, flag_status_o[FSR_PSUSP]);
    idle(PC);
    chk("wip_o", 1, wip_o);
    cmd(OP_RESUME, 1);
    chk("suspend flag", 0, flag_status_o[FSR_PSUSP]);
    wait_wip(0);
    cmd(OP_WRITE_ENABLE, 1);
    prog(OP_PROG_SINGLE, 1, 32'h800, 3, 2, 0, 2);
    wait_wip(1);
    force_fail_i = 1'b1;
    wait_wip(0);
    force_fail_i = 1'b0;
    idle(3);
    chk("wel_o", 0, wel_o);
    chk("fail flag", 1, flag_status_o[FSR_PFAIL]);
    cmd(OP_CLEAR_FLAGS, 1);
    $display("suspend and timeout test done");
    cmd(OP_ENTER_4B, 1);
    chk("addr4_o", 1, addr4_o);
    cmd(OP_WRITE_ENABLE, 1);
    prog(OP_PROG_SINGLE, 1, 32'h0300_0900, 4, 3, 0, 1);
    wait_wip(1);
    wait_wip(0);
    cmd(OP_EXIT_4B, 1);
    chk("addr4_o", 0, addr4_o);
    nv_addr4_i = 1'b1;
    idle(4);
    chk("addr4_o", 1, addr4_o);
    $display("address mode test done");
    wrap_up();
  end
endmodule
